// ===== hdl/drive_mode_regs.svh
// Parameter numbers, field positions, reset values and timing counts
// of the drive mode and miscellaneous parameter block.
// Assumes it is included by bare name wherever the constants are needed.
//
// Overview of operation
// - Last error is 16 bits read only: sub number 0-9, main number 1-96.
// - No active error reads as zero, which is not a valid code.
// - Cam control: bits 7..0 pick the table, bit 16 enables; resets 0.
// - Compensation control: bits 7..0 table, bit 16 enables; resets 0.
// - Telegram 0xe0 selects positioning, 0xe1 selects speed control.
// - Only positioning and speed control are selectable; others refused.
// - Eight-bit mode parameter: 0x08 speed control, 0x10 positioning.
// - A mode change takes several cycles; read the mode parameter back.
// - Speed control with active fieldbus feeds fixed setpoint 1 to adder.
// - Setpoint disabled in control word 1 feeds nothing to the adder.
// - Homing from control word 1 obeys the global homing options.
// - Positioning starts only on a rising edge of the start bit.
// - Positioning starts even when no homing run has completed.
// - A control word 1 bit selects absolute or relative target.
// - A control word 1 bit selects abort or append of the running move.
// - Appended moves end at profile velocity and hand over directly.
// - Control word 1 is a 16-bit word of command bits; bit 6 is both setpoint enable and start.
`ifndef DRIVE_MODE_REGS_SVH
`define DRIVE_MODE_REGS_SVH

// Parameter numbers and subindexes.
`define NUM_LAST_ERROR 16'h0640
`define NUM_CAM_CTRL 16'h05e6
`define NUM_OP_MODE 16'h05dc
`define SUB_CAM 8'h00
`define SUB_COMP 8'h01
`define SUB_ZERO 8'h00

// Field positions and codes.
`define TBL_NO_MSB 7
`define TBL_EN_BIT 16
`define ERR_SUB_MSB 3
`define ERR_SUB_MAX 4'h9
`define ERR_MAIN_MIN 12'h001
`define ERR_MAIN_MAX 12'h060
`define MODE_CODE_SPEED 8'h08
`define MODE_CODE_POS 8'h10
`define TLG_ID_POS 8'he0
`define TLG_ID_SPEED 8'he1

// Control word 1 bit positions.
`define CW1_SP_ENABLE 6
`define CW1_START 6
`define CW1_HOME 11
`define CW1_RELATIVE 12
`define CW1_APPEND 13

// Reset values and timing.
`define CTRL_RESET 32'h0000_0000
`define MODE_SWITCH_CYC 3'h4

`endif

// ===== hdl/drive_mode_pkg.sv
// Types shared by the drive mode parameter block.
// Assumes the constants header sits in the same include path.
`include "drive_mode_regs.svh"

package drive_mode_pkg;
    typedef enum logic [7:0] {
        MODE_SPEED = `MODE_CODE_SPEED,
        MODE_POS = `MODE_CODE_POS
    } op_mode_t;

    // Gray coded along idle, wait, apply.
    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_WAIT = 2'h1,
        SW_APPLY = 2'h3
    } sw_state_t;

    typedef enum logic {
        SP_NONE = 1'h0,
        SP_FIXED1 = 1'h1
    } sp_src_t;

    typedef struct packed {
        logic sp_enable;
        logic start_rise;
        logic home_rise;
        logic relative;
        logic append;
    } cw1_cmd_t;
endpackage

// ===== hdl/cw1_decoder.sv
// Control word 1 decoder: splits the word into command bits and finds
// rising edges of the start and homing bits.
// Assumes control word 1 is synchronous to clk_i.
module cw1_decoder
    import drive_mode_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] cw1_i,
    output cw1_cmd_t cmd_o
);
    logic start_prev_reg;
    logic home_prev_reg;

    // Each bit is read on its own; no field spans two bits.
    assign cmd_o.sp_enable = cw1_i[`CW1_SP_ENABLE];
    assign cmd_o.relative = cw1_i[`CW1_RELATIVE];
    assign cmd_o.append = cw1_i[`CW1_APPEND];
    // A level that stays high gives no second edge.
    assign cmd_o.start_rise = cw1_i[`CW1_START] & ~start_prev_reg;
    assign cmd_o.home_rise = cw1_i[`CW1_HOME] & ~home_prev_reg;

    // Previous levels of the edge-sensitive bits.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_prev_reg <= 1'h0;
            home_prev_reg <= 1'h0;
        end else begin
            start_prev_reg <= cw1_i[`CW1_START];
            home_prev_reg <= cw1_i[`CW1_HOME];
        end
    end

    AST_START_EDGE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_o.start_rise |-> !$past(cw1_i[`CW1_START]))
        else $error("Start reported without a rising edge.");
endmodule

// ===== hdl/drive_mode_params.sv
// Mode and miscellaneous parameter block of the servo drive: last error,
// cam and compensation control, operating mode and control word 1.
// Assumes parameter requests, telegrams and control word 1 arrive
// synchronous to clk_i from the fieldbus front end.
module drive_mode_params
    import drive_mode_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Parameter access port.
    input wire logic param_req_i,
    input wire logic param_wr_i,
    input wire logic [15:0] param_num_i,
    input wire logic [7:0] param_sub_i,
    input wire logic [31:0] param_wdata_i,
    output logic param_ack_o,
    output logic param_err_o,
    output logic [31:0] param_rdata_o,
    // Cyclic receive telegram identifier.
    input wire logic tlg_valid_i,
    input wire logic [7:0] tlg_id_i,
    // Control word 1 and communication state.
    input wire logic [15:0] cw1_i,
    input wire logic comm_active_i,
    // Error reporting from the drive.
    input wire logic err_set_i,
    input wire logic [15:0] err_code_i,
    input wire logic err_clear_i,
    // Global homing option.
    input wire logic home_to_zero_opt_i,
    // Outputs to the motion logic.
    output logic error_active_o,
    output logic [7:0] cam_table_o,
    output logic cam_enable_o,
    output logic [7:0] comp_table_o,
    output logic comp_enable_o,
    output op_mode_t mode_o,
    output logic mode_busy_o,
    output sp_src_t adder_src_o,
    output logic pos_start_o,
    output logic pos_relative_o,
    output logic pos_append_o,
    output logic homing_start_o,
    output logic homing_to_zero_o
);
    // Checks a 16-bit error code for the legal sub and main ranges.
    function automatic logic err_code_ok(input logic [15:0] code);
        logic [11:0] main_no;
        logic [3:0] sub_no;
        main_no = code[15:`ERR_SUB_MSB+1];
        sub_no = code[`ERR_SUB_MSB:0];
        err_code_ok = (sub_no <= `ERR_SUB_MAX) &&
            (main_no >= `ERR_MAIN_MIN) && (main_no <= `ERR_MAIN_MAX);
    endfunction

    // Matches a parameter number and subindex pair.
    function automatic logic num_hit(input logic [15:0] num,
        input logic [7:0] sub, input logic [15:0] ref_num,
        input logic [7:0] idx);
        num_hit = (num == ref_num) && (sub == idx);
    endfunction

    // Tells whether an 8-bit code names a selectable mode.
    function automatic logic mode_ok(input logic [7:0] code);
        mode_ok = (code == `MODE_CODE_SPEED) || (code == `MODE_CODE_POS);
    endfunction

    cw1_cmd_t cmd;
    logic [15:0] last_err_reg;
    logic [15:0] last_err_next;
    logic [31:0] cam_ctl_reg;
    logic [31:0] comp_ctl_reg;
    op_mode_t mode_active_reg;
    op_mode_t mode_target_reg;
    sw_state_t sw_state_reg;
    sw_state_t sw_state_next;
    logic [2:0] sw_cnt_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    sp_src_t adder_src_reg;
    logic pos_start_reg;
    logic pos_relative_reg;
    logic pos_append_reg;
    logic homing_start_reg;
    logic homing_zero_reg;

    cw1_decoder u_cw1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cw1_i(cw1_i),
        .cmd_o(cmd)
    );

    // Parameter address decode.
    wire hit_err = num_hit(param_num_i, param_sub_i,
        `NUM_LAST_ERROR, `SUB_ZERO);
    wire hit_cam = num_hit(param_num_i, param_sub_i,
        `NUM_CAM_CTRL, `SUB_CAM);
    wire hit_comp = num_hit(param_num_i, param_sub_i,
        `NUM_CAM_CTRL, `SUB_COMP);
    wire hit_mode = num_hit(param_num_i, param_sub_i,
        `NUM_OP_MODE, `SUB_ZERO);
    wire hit_any = hit_err | hit_cam | hit_comp | hit_mode;
    wire wr_req = param_req_i & param_wr_i;

    // Write strobes; the error code strobe only marks the write as refused.
    wire wr_cam = wr_req & hit_cam;
    wire wr_comp = wr_req & hit_comp;
    wire wr_mode_legal = wr_req & hit_mode &
        mode_ok(param_wdata_i[7:0]);
    wire wr_mode_bad = wr_req & hit_mode &
        ~mode_ok(param_wdata_i[7:0]);
    wire wr_err_ro = wr_req & hit_err;

    // Refused accesses: unmapped number, read-only target, illegal mode.
    wire req_refused = param_req_i &
        (~hit_any | wr_err_ro | wr_mode_bad);

    // Read data selection; narrow values sit in the low bits.
    wire [31:0] rd_mux =
        hit_err ? {16'h0000, last_err_reg} :
        hit_cam ? cam_ctl_reg :
        hit_comp ? comp_ctl_reg :
        hit_mode ? {24'h000000, mode_active_reg} :
        32'h0000_0000;

    // Mode requests from the telegram identifier.
    wire tlg_pos = tlg_valid_i && (tlg_id_i == `TLG_ID_POS);
    wire tlg_speed = tlg_valid_i && (tlg_id_i == `TLG_ID_SPEED);
    // Unknown identifiers request nothing.
    wire tlg_hit = tlg_pos | tlg_speed;
    // A parameter write takes priority over a telegram in the same cycle.
    wire op_mode_t mode_req = wr_mode_legal ?
        op_mode_t'(param_wdata_i[7:0]) :
        (tlg_pos ? MODE_POS : MODE_SPEED);
    wire mode_go = (wr_mode_legal | tlg_hit) &&
        (mode_req != mode_target_reg);
    wire sw_done = (sw_cnt_reg == `MODE_SWITCH_CYC - 3'h1);

    // Last error update; a new error with a legal code wins over a clear in the same cycle.
    always_comb begin
        last_err_next = last_err_reg;
        if (err_set_i && err_code_ok(err_code_i)) begin
            last_err_next = err_code_i;
        end else if (err_clear_i) begin
            last_err_next = 16'h0000;
        end
    end

    // Last error register; the parameter port never writes it.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_err_reg <= 16'h0000;
        end else begin
            last_err_reg <= last_err_next;
        end
    end

    // Cam and compensation control words.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cam_ctl_reg <= `CTRL_RESET;
            comp_ctl_reg <= `CTRL_RESET;
        end else begin
            if (wr_cam) begin
                cam_ctl_reg <= param_wdata_i;
            end
            if (wr_comp) begin
                comp_ctl_reg <= param_wdata_i;
            end
        end
    end

    // Mode switch sequencer: next state.
    always_comb begin
        sw_state_next = sw_state_reg;
        unique case (sw_state_reg)
            SW_IDLE: begin
                if (mode_go) begin
                    sw_state_next = SW_WAIT;
                end
            end
            SW_WAIT: begin
                if (!mode_go && sw_done) begin
                    sw_state_next = SW_APPLY;
                end
            end
            SW_APPLY: begin
                sw_state_next = mode_go ? SW_WAIT : SW_IDLE;
            end
            default: begin
                sw_state_next = SW_IDLE;
            end
        endcase
    end

    // Mode switch sequencer: a new request restarts the wait.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_state_reg <= SW_IDLE;
            sw_cnt_reg <= 3'h0;
            mode_target_reg <= MODE_POS;
        end else begin
            sw_state_reg <= sw_state_next;
            sw_cnt_reg <= (mode_go || sw_state_reg != SW_WAIT) ?
                3'h0 : sw_cnt_reg + 3'h1;
            if (mode_go) begin
                mode_target_reg <= mode_req;
            end
        end
    end

    // The effective mode changes only when the switch completes.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_active_reg <= MODE_POS;
        end else if (sw_state_reg == SW_APPLY) begin
            mode_active_reg <= mode_target_reg;
        end
    end

    // Parameter answers, one cycle after the request.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'h0;
            err_reg <= 1'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= param_req_i;
            err_reg <= req_refused;
            if (param_req_i && !param_wr_i) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // Adder source: fixed setpoint 1 only while speed control runs.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adder_src_reg <= SP_NONE;
        end else if (mode_active_reg == MODE_SPEED && comm_active_i &&
                cmd.sp_enable) begin
            adder_src_reg <= SP_FIXED1;
        end else begin
            adder_src_reg <= SP_NONE;
        end
    end

    // Positioning and homing starts; no homing run is required first.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_start_reg <= 1'h0;
            pos_relative_reg <= 1'h0;
            pos_append_reg <= 1'h0;
            homing_start_reg <= 1'h0;
            homing_zero_reg <= 1'h0;
        end else begin
            pos_start_reg <= (mode_active_reg == MODE_POS) &&
                cmd.start_rise;
            homing_start_reg <= (mode_active_reg == MODE_POS) &&
                cmd.home_rise;
            if (mode_active_reg == MODE_POS && cmd.start_rise) begin
                pos_relative_reg <= cmd.relative;
                pos_append_reg <= cmd.append;
            end
            if (mode_active_reg == MODE_POS && cmd.home_rise) begin
                homing_zero_reg <= home_to_zero_opt_i;
            end
        end
    end

    // Output assignments.
    assign param_ack_o = ack_reg;
    assign param_err_o = err_reg;
    assign param_rdata_o = rdata_reg;
    assign error_active_o = (last_err_reg != 16'h0000);
    assign cam_table_o = cam_ctl_reg[`TBL_NO_MSB:0];
    assign cam_enable_o = cam_ctl_reg[`TBL_EN_BIT];
    assign comp_table_o = comp_ctl_reg[`TBL_NO_MSB:0];
    assign comp_enable_o = comp_ctl_reg[`TBL_EN_BIT];
    assign mode_o = mode_active_reg;
    assign mode_busy_o = (sw_state_reg != SW_IDLE);
    assign adder_src_o = adder_src_reg;
    assign pos_start_o = pos_start_reg;
    assign pos_relative_o = pos_relative_reg;
    assign pos_append_o = pos_append_reg;
    assign homing_start_o = homing_start_reg;
    assign homing_to_zero_o = homing_zero_reg;

    // A stored error code always lies in the legal ranges.
    AST_ERR_RANGE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        error_active_o |-> err_code_ok(last_err_reg))
        else $error("Stored error code out of range.");
    // A clear without a new error leaves zero behind.
    AST_ERR_CLEAR: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        err_clear_i && !err_set_i |=> last_err_reg == 16'h0000)
        else $error("Error code not cleared to zero.");
    // Cam write lands in table number and enable.
    AST_CAM_WRITE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_cam |=> cam_table_o == $past(param_wdata_i[7:0]) &&
            cam_enable_o == $past(param_wdata_i[16]))
        else $error("Cam control not updated.");
    // Compensation write lands in table number and enable.
    AST_COMP_WRITE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_comp |=> comp_table_o == $past(param_wdata_i[7:0]) &&
            comp_enable_o == $past(param_wdata_i[16]))
        else $error("Compensation control not updated.");
    // A telegram for a new mode takes effect after the switch wait.
    AST_TLG_MODE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sw_state_reg == SW_IDLE && !wr_mode_legal && tlg_speed &&
            mode_target_reg == MODE_POS ##1 !mode_go [*5]
            |=> mode_o == MODE_SPEED)
        else $error("Telegram did not select speed control.");
    // Only the two documented modes ever appear.
    AST_MODE_LEGAL: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        mode_ok(mode_o) && mode_ok(mode_target_reg))
        else $error("Illegal operating mode.");
    // An illegal mode write is refused.
    AST_MODE_REFUSE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_mode_bad |=> param_err_o && param_ack_o)
        else $error("Illegal mode write accepted.");
    // The switch stays busy for the whole wait.
    AST_SWITCH_BUSY: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(mode_busy_o) |-> mode_busy_o [*5])
        else $error("Mode switch ended early.");
    // Adder source follows mode, link and setpoint enable.
    AST_ADDER_SRC: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 (adder_src_o == SP_FIXED1) == ($past(mode_o) == MODE_SPEED &&
            $past(comm_active_i) && $past(cmd.sp_enable)))
        else $error("Adder source wrong.");
    // Disabled setpoint feeds nothing.
    AST_ADDER_OFF: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !cmd.sp_enable |=> adder_src_o == SP_NONE)
        else $error("Setpoint fed while disabled.");
    // Homing start carries the global zero option.
    AST_HOME_OPT: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        homing_start_o |-> homing_to_zero_o == $past(home_to_zero_opt_i))
        else $error("Homing option not applied.");
    // A start edge in positioning always starts a move.
    AST_POS_START: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        mode_o == MODE_POS && cmd.start_rise |=> pos_start_o &&
            pos_relative_o == $past(cmd.relative) &&
            pos_append_o == $past(cmd.append))
        else $error("Positioning start lost.");
    // A write to the error code is refused and changes nothing.
    AST_ERR_RO: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_err_ro && !err_set_i && !err_clear_i |=>
            param_err_o && $stable(last_err_reg))
        else $error("Error code write not refused.");
endmodule

// ===== sim/fieldbus_master_model.sv
// Behavioural fieldbus master: parameter accesses, telegrams, cw1.
// Assumes its tasks are called just after a rising edge of clk_i.
module fieldbus_master_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [31:0] rdata_i,
    output logic req_o,
    output logic wr_o,
    output logic [15:0] num_o,
    output logic [7:0] sub_o,
    output logic [31:0] wdata_o,
    output logic tlg_valid_o,
    output logic [7:0] tlg_id_o,
    output logic [15:0] cw1_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle lines start at zero.
    initial begin
        {req_o, wr_o, num_o, sub_o, wdata_o} = '0;
        {tlg_valid_o, tlg_id_o, cw1_o} = '0;
    end

    // One-cycle request, then a bounded wait for the answer pulse.
    task automatic access(input logic wr, input logic [15:0] num,
            input logic [7:0] sub, input logic [31:0] wd,
            output logic e, output logic [31:0] rd, output logic to);
        int n;
        req_o = 1'b1;
        wr_o = wr;
        num_o = num;
        sub_o = sub;
        wdata_o = wd;
        @(posedge clk_i);
        #1;
        req_o = 1'b0;
        num_o = ~num;
        sub_o = ~sub;
        wdata_o = ~wd;
        n = 0;
        while (ack_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        e = err_i;
        rd = rdata_i;
        to = (n == 4);
        // One edge passes so that a following request never meets this release.
        @(posedge clk_i);
        #1;
    endtask

    // A telegram identifier stands for one cycle; the call returns a cycle later.
    task automatic send_tlg(input logic [7:0] id);
        tlg_valid_o = 1'b1;
        tlg_id_o = id;
        @(posedge clk_i);
        #1;
        tlg_valid_o = 1'b0;
        tlg_id_o = ~id;
        @(posedge clk_i);
        #1;
    endtask

    // The whole 16-bit word is handed over at once.
    task automatic set_cw1(input logic [15:0] v);
        cw1_o = v;
    endtask
endmodule

// ===== sim/drive_mode_params_tb.sv
// Self-checking bench of the drive mode parameter block.
// Assumes the constants header is on the include path.
`include "drive_mode_regs.svh"

module drive_mode_params_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import drive_mode_pkg::*;

    logic clk_i, rst_n_i, req, wr, ack, err, tlg_valid;
    logic [15:0] num, cw1, err_code_i;
    logic [7:0] sub, tlg_id, cam_table_o, comp_table_o;
    logic [31:0] wdata, rdata;
    logic comm_active_i, err_set_i, err_clear_i, home_to_zero_opt_i;
    logic error_active_o, cam_enable_o, comp_enable_o, mode_busy_o;
    logic pos_start_o, pos_relative_o, pos_append_o;
    logic homing_start_o, homing_to_zero_o;
    op_mode_t mode_o;
    sp_src_t adder_src_o;
    int num_errors = 0;
    int check_count = 0;

    // The device under test and the master in front of it.
    drive_mode_params dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .param_req_i(req), .param_wr_i(wr), .param_num_i(num),
        .param_sub_i(sub), .param_wdata_i(wdata), .param_ack_o(ack),
        .param_err_o(err), .param_rdata_o(rdata), .tlg_valid_i(tlg_valid),
        .tlg_id_i(tlg_id), .cw1_i(cw1), .comm_active_i(comm_active_i),
        .err_set_i(err_set_i), .err_code_i(err_code_i),
        .err_clear_i(err_clear_i), .home_to_zero_opt_i(home_to_zero_opt_i),
        .error_active_o(error_active_o), .cam_table_o(cam_table_o),
        .cam_enable_o(cam_enable_o), .comp_table_o(comp_table_o),
        .comp_enable_o(comp_enable_o), .mode_o(mode_o),
        .mode_busy_o(mode_busy_o), .adder_src_o(adder_src_o),
        .pos_start_o(pos_start_o), .pos_relative_o(pos_relative_o),
        .pos_append_o(pos_append_o), .homing_start_o(homing_start_o),
        .homing_to_zero_o(homing_to_zero_o));
    fieldbus_master_model master_u (.clk_i(clk_i), .ack_i(ack),
        .err_i(err), .rdata_i(rdata), .req_o(req), .wr_o(wr), .num_o(num),
        .sub_o(sub), .wdata_o(wdata), .tlg_valid_o(tlg_valid),
        .tlg_id_o(tlg_id), .cw1_o(cw1));

    // Free-running 50 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic end_sim();
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Parameter access with its refusal flag checked; a hang ends the run.
    task automatic pa(input logic w, input logic [15:0] n,
            input logic [7:0] s, input logic [31:0] d, input logic xe,
            output logic [31:0] r);
        logic e, to;
        master_u.access(w, n, s, d, e, r, to);
        check("param answer", 32'h0, 32'(to));
        check("param refusal", 32'(xe), 32'(e));
        if (to) end_sim();
    endtask

    task automatic rd_chk(input logic [15:0] n, input logic [7:0] s,
            input logic [31:0] x);
        logic [31:0] r;
        pa(1'b0, n, s, 32'h0, 1'b0, r);
        check("read data", x, r);
    endtask

    // Waits out a mode switch and checks its length and result.
    task automatic wait_mode(input logic [7:0] x);
        int n;
        n = 0;
        while (mode_busy_o !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // One of the busy cycles passes inside the call that made the request.
        check("switch cycles", 32'(`MODE_SWITCH_CYC), 32'(n));
        check("mode", 32'(x), 32'(mode_o));
        if (n == 20) end_sim();
    endtask

    task automatic err_ev(input logic set, input logic [15:0] c);
        err_set_i = set;
        err_clear_i = !set;
        err_code_i = c;
        @(posedge clk_i);
        #1;
        err_set_i = 1'b0;
        err_clear_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic cw(input logic [15:0] v);
        master_u.set_cw1(v);
        @(posedge clk_i);
        #1;
    endtask

    // Main sequence of accesses and expected values.
    initial begin
        logic [31:0] r;
        rst_n_i = 1'b0;
        {comm_active_i, err_set_i, err_clear_i, home_to_zero_opt_i} = '0;
        err_code_i = 16'h0;
        repeat (20) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        check("reset mode", 32'(`MODE_CODE_POS), 32'(mode_o));
        rd_chk(`NUM_LAST_ERROR, `SUB_ZERO, 32'h0);
        rd_chk(`NUM_CAM_CTRL, `SUB_CAM, `CTRL_RESET);
        rd_chk(`NUM_CAM_CTRL, `SUB_COMP, `CTRL_RESET);
        err_ev(1'b1, 16'h0609);
        check("error active", 32'h1, 32'(error_active_o));
        rd_chk(`NUM_LAST_ERROR, `SUB_ZERO, 32'h0609);
        pa(1'b1, `NUM_LAST_ERROR, `SUB_ZERO, 32'h0, 1'b1, r);
        err_ev(1'b1, 16'h0619);
        err_ev(1'b1, 16'h001a);
        rd_chk(`NUM_LAST_ERROR, `SUB_ZERO, 32'h0609);
        err_ev(1'b0, 16'h0);
        rd_chk(`NUM_LAST_ERROR, `SUB_ZERO, 32'h0);
        check("error active", 32'h0, 32'(error_active_o));
        pa(1'b1, `NUM_CAM_CTRL, `SUB_CAM, 32'h0001_00a5, 1'b0, r);
        check("cam", 32'h1a5, {cam_enable_o, cam_table_o});
        pa(1'b1, `NUM_CAM_CTRL, `SUB_COMP, 32'h0001_0007, 1'b0, r);
        check("comp", 32'h107, {comp_enable_o, comp_table_o});
        pa(1'b1, `NUM_CAM_CTRL, `SUB_CAM, 32'h0000_00ff, 1'b0, r);
        check("cam", 32'h0ff, {cam_enable_o, cam_table_o});
        rd_chk(`NUM_CAM_CTRL, `SUB_COMP, 32'h0001_0007);
        pa(1'b1, `NUM_CAM_CTRL, 8'h02, 32'h0, 1'b1, r);
        pa(1'b1, `NUM_OP_MODE, `SUB_ZERO, 32'h20, 1'b1, r);
        master_u.send_tlg(8'h55);
        check("busy", 32'h0, 32'(mode_busy_o));
        pa(1'b1, `NUM_OP_MODE, `SUB_ZERO, 32'h08, 1'b0, r);
        wait_mode(`MODE_CODE_SPEED);
        rd_chk(`NUM_OP_MODE, `SUB_ZERO, 32'h08);
        master_u.send_tlg(`TLG_ID_POS);
        wait_mode(`MODE_CODE_POS);
        master_u.send_tlg(`TLG_ID_SPEED);
        wait_mode(`MODE_CODE_SPEED);
        comm_active_i = 1'b1;
        cw(16'h0040);
        check("adder", 32'(SP_FIXED1), 32'(adder_src_o));
        check("start", 32'h0, 32'(pos_start_o));
        cw(16'h0000);
        check("adder", 32'(SP_NONE), 32'(adder_src_o));
        master_u.send_tlg(`TLG_ID_POS);
        wait_mode(`MODE_CODE_POS);
        cw(16'h3040);
        check("start", 32'h7, {pos_start_o, pos_relative_o,
            pos_append_o});
        cw(16'h3040);
        check("start held", 32'h0, 32'(pos_start_o));
        home_to_zero_opt_i = 1'b1;
        cw(16'h3840);
        check("homing", 32'h3, {homing_start_o, homing_to_zero_o});
        cw(16'h0000);
        cw(16'h0040);
        check("start", 32'h4, {pos_start_o, pos_relative_o,
            pos_append_o});
        end_sim();
    end
endmodule
